// File: pkg/port_output_disable_regs.svh
`ifndef PORT_OUTPUT_DISABLE_REGS_SVH
`define PORT_OUTPUT_DISABLE_REGS_SVH

// Register byte offsets
`define OFS_IN0_CTL      8'h00
`define OFS_IN4_CTL      8'h04
`define OFS_IN8_CTL      8'h08
`define OFS_IN10_CTL     8'h0C
`define OFS_IN11_CTL     8'h10
`define OFS_SW_HIZ       8'h14
`define OFS_CH0_HIZ_EN   8'h18
`define OFS_PAIR_HIZ_EN  8'h1C
`define OFS_STATUS       8'h20

// Input control/status fields
`define ICS_MODE_LSB     0
`define ICS_HIZ_EN       8
`define ICS_IRQ_EN       9
`define ICS_FLAG         12

// Software request fields
`define SW_CH34          0
`define SW_CH67          1
`define SW_CH0           2

// Pair enable and status fields
`define PAIR_IRQ_EN      8
`define STAT_OSC         8

// Reset values
`define RST_ZERO8        8'h00

// Counts and prescaler masks
`define N_IN             5
`define N_PIN            16
`define N_PAIR           6
`define LOW_SAMPLES      5'h10
`define DIV8_MASK        7'h07
`define DIV16_MASK       7'h0F
`define DIV128_MASK      7'h7F

`endif

// File: pkg/port_output_disable_pkg.sv
`include "port_output_disable_regs.svh"

package port_output_disable_pkg;

	typedef enum logic [1:0] {
		DET_EDGE,
		DET_DIV8,
		DET_DIV16,
		DET_DIV128
	} det_mode_e;

	typedef struct packed {
		logic                         ack;
		logic [31:0]                  rdat;
		logic [`N_IN-1:0][1:0]        mode;
		logic [`N_IN-1:0]             hiz_en;
		logic [`N_IN-1:0]             irq_en;
		logic [`N_IN-1:0]             flag;
		logic [`N_IN-1:0]             prev;
		logic [`N_IN-1:0][4:0]        low_cnt;
		logic [2:0]                   sw;
		logic [3:0]                   ch0_en;
		logic [`N_PAIR-1:0]           pair_en;
		logic                         pair_irq_en;
		logic [`N_PAIR-1:0]           short_flag;
		logic                         osc_flag;
		logic [6:0]                   presc;
	} state_s;

endpackage

// File: rtl/port_output_disable.sv
`timescale 1ns/1ps
// Overview of operation
// - Sixteen target pins: channel 0 all, 3 B/D, 4 all, 6 B/D, 7 all.
// - Five request inputs, each falling edge or 16 low samples at PCLK/8/16/128.
// - Enabled request detection drives all controlled target pins high impedance.
// - Both pins of a pair active together one cycle forces them high impedance.
// - Pairs watched: 3 B/D, 4 A/C, 4 B/D, 6 B/D, 7 A/C, 7 B/D.
// - Main oscillator stop report forces all controlled target pins high impedance.
// - Software request bits force their pin groups high impedance directly.
// - Interrupt requests come from input sampling and output comparison results.
// - Software register: channels 6/7 at b1, channel 0 at b2, channels 3/4.
// - Each channel 0 pin goes high impedance only when its own enable is set.
// - Input 10 has mode, enable and flag in one control/status register.
`include "port_output_disable_regs.svh"
module port_output_disable
	import port_output_disable_pkg::*;
#(
	parameter bit ACTIVE_LEVEL = 1'b1
) (
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	input  wire logic              cyc_i,
	input  wire logic              stb_i,
	input  wire logic              we_i,
	input  wire logic [7:0]        adr_i,
	input  wire logic [3:0]        sel_i,
	input  wire logic [31:0]       dat_i,
	output logic      [31:0]       dat_o,
	output logic                   ack_o,
	input  wire logic              fault_req_in_0_i,
	input  wire logic              fault_req_in_4_i,
	input  wire logic              fault_req_in_8_i,
	input  wire logic              fault_req_in_10_i,
	input  wire logic              fault_req_in_11_i,
	input  wire logic              osc_stop_i,
	input  wire logic [`N_PIN-1:0] pin_level_i,
	output logic      [`N_PIN-1:0] pin_hiz_o,
	output logic                   input_irq_o,
	output logic                   short_irq_o
);

	// Pin order: ch0 a,b,c,d; ch3 b,d; ch4 a,b,c,d; ch6 b,d; ch7 a,b,c,d
	localparam int PAIR_P [`N_PAIR] = '{4, 6, 7, 10, 12, 13};
	localparam int PAIR_N [`N_PAIR] = '{5, 8, 9, 11, 14, 15};

	state_s r_r;
	state_s r_nxt;

	logic [`N_IN-1:0]   req_in;
	logic [`N_IN-1:0]   det;
	logic [`N_IN-1:0]   tick;
	logic [`N_PAIR-1:0] short_now;
	logic               access;
	logic               wr_lo;
	logic               wr_hi;
	logic               global_hiz;
	logic               grp0;
	logic               grp34;
	logic               grp67;

	assign req_in = {fault_req_in_11_i, fault_req_in_10_i, fault_req_in_8_i,
		fault_req_in_4_i, fault_req_in_0_i};

	// Shared prescaler keeps all sampling inputs phase aligned
	genvar gi;
	generate
		for (gi = 0; gi < `N_IN; gi++) begin : g_in
			always_comb begin
				unique case (det_mode_e'(r_r.mode[gi]))
					DET_EDGE:   tick[gi] = 1'b1;
					DET_DIV8:   tick[gi] = (r_r.presc & `DIV8_MASK) == `DIV8_MASK;
					DET_DIV16:  tick[gi] = (r_r.presc & `DIV16_MASK) == `DIV16_MASK;
					DET_DIV128: tick[gi] = r_r.presc == `DIV128_MASK;
				endcase
				if (det_mode_e'(r_r.mode[gi]) == DET_EDGE) begin
					det[gi] = r_r.prev[gi] & ~req_in[gi];
				end else begin
					det[gi] = tick[gi] & ~req_in[gi] && r_r.low_cnt[gi] == `LOW_SAMPLES - 5'h01;
				end
			end
		end
		for (gi = 0; gi < `N_PAIR; gi++) begin : g_pair
			assign short_now[gi] = r_r.pair_en[gi] && pin_level_i[PAIR_P[gi]] == ACTIVE_LEVEL
				&& pin_level_i[PAIR_N[gi]] == ACTIVE_LEVEL;
		end
	endgenerate

	// Write lands at the edge where the master sees ack
	assign access = cyc_i & stb_i;
	assign wr_lo  = access & we_i & r_r.ack & sel_i[0];
	assign wr_hi  = access & we_i & r_r.ack & sel_i[1];

	function automatic logic [31:0] read_word(input state_s s, input logic [7:0] a);
		logic [31:0] w;
		w = 32'h0000_0000;
		unique case (a)
			`OFS_IN0_CTL, `OFS_IN4_CTL, `OFS_IN8_CTL, `OFS_IN10_CTL, `OFS_IN11_CTL: begin
				w[`ICS_MODE_LSB +: 2] = s.mode[a[4:2]];
				w[`ICS_HIZ_EN]        = s.hiz_en[a[4:2]];
				w[`ICS_IRQ_EN]        = s.irq_en[a[4:2]];
				w[`ICS_FLAG]          = s.flag[a[4:2]];
			end
			`OFS_SW_HIZ:      w[2:0] = s.sw;
			`OFS_CH0_HIZ_EN:  w[3:0] = s.ch0_en;
			`OFS_PAIR_HIZ_EN: begin
				w[`N_PAIR-1:0]  = s.pair_en;
				w[`PAIR_IRQ_EN] = s.pair_irq_en;
			end
			`OFS_STATUS: begin
				w[`N_PAIR-1:0] = s.short_flag;
				w[`STAT_OSC]   = s.osc_flag;
			end
			default: w = 32'h0000_0000;
		endcase
		return w;
	endfunction

	always_comb begin
		int idx;
		idx = 0;
		r_nxt = r_r;
		r_nxt.presc = r_r.presc + 7'h01;
		r_nxt.prev  = req_in;
		// Bus handshake: one-cycle ack, dropped after
		r_nxt.ack  = access & ~r_r.ack;
		r_nxt.rdat = (access & ~r_r.ack) ? read_word(r_r, adr_i) : r_r.rdat;
		for (int i = 0; i < `N_IN; i++) begin
			if (tick[i] && det_mode_e'(r_r.mode[i]) != DET_EDGE) begin
				if (!req_in[i] && r_r.low_cnt[i] != `LOW_SAMPLES) begin
					r_nxt.low_cnt[i] = r_r.low_cnt[i] + 5'h01;
				end else if (req_in[i]) begin
					r_nxt.low_cnt[i] = 5'h00;
				end
			end
		end
		// Software side first so hardware sets below win
		if (wr_lo) begin
			unique case (adr_i)
				`OFS_IN0_CTL, `OFS_IN4_CTL, `OFS_IN8_CTL, `OFS_IN10_CTL, `OFS_IN11_CTL: begin
					idx = int'(adr_i[4:2]);
					r_nxt.mode[idx] = dat_i[`ICS_MODE_LSB +: 2];
					r_nxt.low_cnt[idx] = 5'h00;
				end
				`OFS_SW_HIZ:      r_nxt.sw = dat_i[2:0];
				`OFS_CH0_HIZ_EN:  r_nxt.ch0_en = dat_i[3:0];
				`OFS_PAIR_HIZ_EN: r_nxt.pair_en = dat_i[`N_PAIR-1:0];
				`OFS_STATUS:      r_nxt.short_flag = r_r.short_flag & ~dat_i[`N_PAIR-1:0];
				default:          r_nxt.sw = r_r.sw;
			endcase
		end
		if (wr_hi) begin
			unique case (adr_i)
				`OFS_IN0_CTL, `OFS_IN4_CTL, `OFS_IN8_CTL, `OFS_IN10_CTL, `OFS_IN11_CTL: begin
					idx = int'(adr_i[4:2]);
					r_nxt.hiz_en[idx] = dat_i[`ICS_HIZ_EN];
					r_nxt.irq_en[idx] = dat_i[`ICS_IRQ_EN];
					if (dat_i[`ICS_FLAG]) begin
						r_nxt.flag[idx] = 1'b0;
					end
				end
				`OFS_PAIR_HIZ_EN: r_nxt.pair_irq_en = dat_i[`PAIR_IRQ_EN];
				`OFS_STATUS: begin
					if (dat_i[`STAT_OSC]) begin
						r_nxt.osc_flag = 1'b0;
					end
				end
				default: r_nxt.sw = r_nxt.sw;
			endcase
		end
		// Hardware sets win over a same-cycle clear
		r_nxt.flag       = r_nxt.flag | det;
		r_nxt.short_flag = r_nxt.short_flag | short_now;
		r_nxt.osc_flag   = r_nxt.osc_flag | osc_stop_i;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			r_r <= '0;
			r_r.prev <= '1;
		end else begin
			r_r <= r_nxt;
		end
	end

	// Flags hold the pins released until cleared
	assign global_hiz = |(r_r.flag & r_r.hiz_en) | r_r.osc_flag;
	assign grp0  = global_hiz | r_r.sw[`SW_CH0];
	assign grp34 = global_hiz | r_r.sw[`SW_CH34];
	assign grp67 = global_hiz | r_r.sw[`SW_CH67];

	always_comb begin
		pin_hiz_o = '0;
		pin_hiz_o[3:0] = {4{grp0}} & r_r.ch0_en;
		pin_hiz_o[9:4] = {6{grp34}};
		pin_hiz_o[15:10] = {6{grp67}};
		for (int p = 0; p < `N_PAIR; p++) begin
			if (r_r.short_flag[p]) begin
				pin_hiz_o[PAIR_P[p]] = 1'b1;
				pin_hiz_o[PAIR_N[p]] = 1'b1;
			end
		end
	end

	assign input_irq_o = |(r_r.flag & r_r.irq_en);
	assign short_irq_o = r_r.pair_irq_en & |r_r.short_flag;
	assign ack_o       = r_r.ack;
	assign dat_o       = r_r.rdat;

endmodule // port_output_disable

// File: sim/port_output_disable_properties.sv
`timescale 1ns/1ps
module port_output_disable_properties (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        cyc_i,
	input wire logic        stb_i,
	input wire logic        we_i,
	input wire logic        ack_o,
	input wire logic        fault_req_in_0_i,
	input wire logic        fault_req_in_4_i,
	input wire logic        fault_req_in_8_i,
	input wire logic        fault_req_in_10_i,
	input wire logic        fault_req_in_11_i,
	input wire logic        osc_stop_i,
	input wire logic [15:0] pin_level_i,
	input wire logic [15:0] pin_hiz_o,
	input wire logic        input_irq_o,
	input wire logic        short_irq_o
);
	logic pr, fl, wr;
	assign pr = |({pin_level_i[13:12], pin_level_i[10], pin_level_i[7:6], pin_level_i[4]}
		& {pin_level_i[15:14], pin_level_i[11], pin_level_i[9:8], pin_level_i[5]});
	assign fl = ~&{fault_req_in_0_i, fault_req_in_4_i, fault_req_in_8_i, fault_req_in_10_i, fault_req_in_11_i};
	assign wr = ack_o & we_i;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("no ack");
	a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack too long");
	a_osc_hiz: assert property (osc_stop_i |=> &pin_hiz_o[15:4]) else $error("osc no hiz");
	a_hiz_cause: assert property ((pin_hiz_o & ~$past(pin_hiz_o)) != 16'h0000 |-> $past(osc_stop_i | pr | fl | wr))
		else $error("hiz no cause");
	a_hiz_hold: assert property ((~pin_hiz_o & $past(pin_hiz_o)) != 16'h0000 |-> $past(wr))
		else $error("hiz dropped");
	a_irq_cause: assert property ($rose(input_irq_o) |-> $past(fl | wr)) else $error("irq no cause");
	a_irq_hold: assert property ($fell(input_irq_o) || $fell(short_irq_o) |-> $past(wr)) else $error("irq dropped");
	a_short_cause: assert property ($rose(short_irq_o) |-> $past(pr | wr)) else $error("short no cause");
	c_osc: cover property (osc_stop_i ##1 pin_hiz_o[15]);
	c_short: cover property ($rose(short_irq_o));
	c_input: cover property ($rose(input_irq_o));
endmodule // port_output_disable_properties
bind port_output_disable port_output_disable_properties u_props (.*);

// File: sim/pwm_pair_model.sv
`timescale 1ns/1ps
module pwm_pair_model (
	input  wire logic        clk_i,
	input  wire logic [15:0] hiz_i,
	input  wire logic [15:0] short_i,
	output logic      [15:0] level_o
);
	logic ph_r = 1'b0;
	always_ff @(posedge clk_i) ph_r <= ~ph_r;
	// Pairs never overlap unless short_i forces both active
	// Released pins read as pulled low, not the last level
	assign level_o = ({~ph_r, ~ph_r, ph_r, ph_r, ~ph_r, ph_r, ~ph_r, ~ph_r, ph_r, ph_r, ~ph_r, {5{ph_r}}} | short_i) & ~hiz_i;
endmodule // pwm_pair_model

// File: sim/port_output_disable_bench.sv
`timescale 1ns/1ps
`include "port_output_disable_regs.svh"
module port_output_disable_bench;
	logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, osc_stop_i = 1'b0;
	logic        ack_o, input_irq_o, short_irq_o;
	logic [7:0]  adr_i = 8'h00;
	logic [3:0]  sel_i = 4'hF;
	logic [31:0] dat_i = 32'h0000_0000, dat_o, r;
	logic [4:0]  flt = 5'h1F;
	logic [15:0] pin_level_i, pin_hiz_o, short_m = 16'h0000;
	logic [15:0] pm [6] = '{16'h0030, 16'h0140, 16'h0280, 16'h0C00, 16'h5000, 16'hA000};
	logic [31:0] q [$];
	int          error_cnt = 0, comparisons = 0, seed = 6200, i, d;
	always #2.5 clk_i = ~clk_i;
	port_output_disable dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
		.sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .fault_req_in_0_i(flt[0]), .fault_req_in_4_i(flt[1]),
		.fault_req_in_8_i(flt[2]), .fault_req_in_10_i(flt[3]), .fault_req_in_11_i(flt[4]), .osc_stop_i(osc_stop_i),
		.pin_level_i(pin_level_i), .pin_hiz_o(pin_hiz_o), .input_irq_o(input_irq_o), .short_irq_o(short_irq_o));
	pwm_pair_model pairs (.clk_i(clk_i), .hiz_i(pin_hiz_o), .short_i(short_m), .level_o(pin_level_i));
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		comparisons++;
		if (s !== e) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i  <= w;
		adr_i <= a;
		dat_i <= d;
		do @(posedge clk_i); while (ack_o !== 1'b1);
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		q.push_back(e);
		wb(1'b0, a, 32'h0000_0000);
	endtask
	task automatic summarize();
		if (q.size() != 0) error_cnt++;
		$display("error_cnt %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// Read data is matched against the oldest noted expectation
	always @(posedge clk_i) begin
		if (ack_o === 1'b1 && we_i === 1'b0 && q.size() > 0) chk("read_data", q.pop_front(), dat_o);
	end
	initial begin
		repeat (5000) @(posedge clk_i);
		error_cnt++;
		summarize();
	end
	initial begin
		r = $random(seed);
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		for (i = 0; i < 10; i++) rd(8'(i * 4), 32'h0000_0000);
		wb(1'b1, `OFS_CH0_HIZ_EN, r & 32'h0000_000F);
		for (i = 0; i < 3; i++) begin
			wb(1'b1, `OFS_SW_HIZ, 32'(1 << i));
			chk("sw_hiz", {{6{i == 1}}, {6{i == 0}}, (i == 2) ? r[3:0] : 4'h0}, pin_hiz_o);
		end
		wb(1'b1, `OFS_SW_HIZ, 32'h0000_0000);
		for (i = 0; i < 5; i++) begin
			wb(1'b1, 8'(i * 4), 32'h0000_0300);
			flt[i] <= 1'b0;
			repeat (3) @(posedge clk_i);
			flt[i] <= 1'b1;
			chk("flt_hiz", {12'hFFF, r[3:0]}, pin_hiz_o);
			chk("flt_irq", 1'b1, input_irq_o);
			rd(8'(i * 4), 32'h0000_1300);
			wb(1'b1, 8'(i * 4), 32'h0000_1300);
			chk("flt_clr", 16'h0000, pin_hiz_o);
		end
		// Sixteen low ticks: first tick after 1 to d cycles, so 15*d+1 to 16*d
		for (i = 1; i < 4; i++) begin
			d = (i == 3) ? 128 : 4 << i;
			wb(1'b1, `OFS_IN4_CTL, 32'h0000_0100 | i);
			flt[1] <= 1'b0;
			repeat (15 * d - 2) @(posedge clk_i);
			chk("lvl_early", 16'h0000, pin_hiz_o);
			repeat (d + 9) @(posedge clk_i);
			flt[1] <= 1'b1;
			chk("lvl_hiz", {12'hFFF, r[3:0]}, pin_hiz_o);
			wb(1'b1, `OFS_IN4_CTL, 32'h0000_1000);
		end
		short_m <= pm[0];
		repeat (3) @(posedge clk_i);
		short_m <= 16'h0000;
		chk("pair_off", 16'h0000, pin_hiz_o);
		wb(1'b1, `OFS_PAIR_HIZ_EN, 32'h0000_013F);
		for (i = 0; i < 6; i++) begin
			short_m <= pm[i];
			repeat (3) @(posedge clk_i);
			short_m <= 16'h0000;
			chk("pair_hiz", pm[i], pin_hiz_o);
			chk("pair_irq", 1'b1, short_irq_o);
			wb(1'b1, `OFS_STATUS, 32'(1 << i));
			chk("pair_clr", 16'h0000, pin_hiz_o);
			chk("pair_irq_clr", 1'b0, short_irq_o);
		end
		osc_stop_i <= 1'b1;
		@(posedge clk_i);
		osc_stop_i <= 1'b0;
		@(posedge clk_i);
		chk("osc_hiz", {12'hFFF, r[3:0]}, pin_hiz_o);
		rd(`OFS_STATUS, 32'h0000_0100);
		wb(1'b1, `OFS_STATUS, 32'h0000_0100);
		chk("osc_clr", 16'h0000, pin_hiz_o);
		summarize();
	end
endmodule // port_output_disable_bench
